// ==== rtl/fdsm_regs.svh ====
// Constants for the drive/motor output and media/drive-type register block.
// Assumes an Avalon-MM slave with 32-bit data, byte addresses = 4 * index.
`ifndef FDSM_REGS_SVH
`define FDSM_REGS_SVH
`define FDSM_IDX_DRIVE_MOTOR_OUTPUT 4'h2
`define FDSM_IDX_MEDIA_DRIVE_TYPE 4'h3
`define FDSM_IDX_CONFIG 4'h0
`define FDSM_IDX_DRIVE_ID 4'h1
`define FDSM_IDX_STATUS 4'h4
`define FDSM_DMO_RESET 8'h00
`define FDSM_MDT_RESET 8'h00
`define FDSM_CFG_RESET 8'h00
`define FDSM_DID_RESET 8'h00
`define FDSM_CFG_FOUR_DRIVE 7
`define FDSM_CFG_ENHANCED 6
`define FDSM_CFG_ALT_MODE 0
`define FDSM_DMO_RUN 2
`define FDSM_DMO_DMA 3
`define FDSM_DMO_MOTOR_LSB 4
`define FDSM_SOFT_RESET_NS 100
`endif

// ==== rtl/fdsm_pkg.sv ====
// Types shared by the drive/motor register block.
// Assumes the constants header is included by the users of this package.
package fdsm_pkg;
	typedef struct packed {
		logic [3:0] drive_sel_n;
		logic [3:0] motor_n;
		logic [1:0] enc_sel;
		logic enc_motor;
	} fdsm_drive_s;
	typedef struct packed {
		logic drq_oe_n;
		logic irq_oe_n;
		logic dack_en;
		logic tc_en;
	} fdsm_dma_s;
endpackage

// ==== rtl/fdsm_top.sv ====
// Drive/motor output, media/drive-type, config and drive-ID registers.
// Assumes a 200 MHz clock, an Avalon-MM master, and async media sense pins.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "fdsm_regs.svh"
module fdsm_top #(
	parameter int CLK_MHZ = 200
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Media sense pins
	input wire logic media_sense_low_in,
	input wire logic media_sense_high_in,
	// Drive side
	output fdsm_pkg::fdsm_drive_s drive_out,
	output logic [1:0] tape_drive_out,
	// Controller control
	output logic ctrl_reset_out,
	output logic soft_reset_pulse_out,
	output fdsm_pkg::fdsm_dma_s dma_out
);
	import fdsm_pkg::*;

	localparam int SOFT_RESET_CYC_RAW = (`FDSM_SOFT_RESET_NS * CLK_MHZ + 999) / 1000;
	localparam int SOFT_RESET_CYC = (SOFT_RESET_CYC_RAW < 1) ? 1 : SOFT_RESET_CYC_RAW;

	logic [7:0] dmo_ff;
	logic [3:0] tape_swap_ff;
	logic [7:0] cfg_ff;
	logic [7:0] did_ff;
	logic [1:0] sense_meta_ff;
	logic [1:0] sense_ff;
	logic ack_ff;
	logic [31:0] rdata_ff;
	logic [7:0] rst_cnt_ff;
	logic run_prev_ff;

	logic wr_acc;
	logic rd_acc;
	logic four_drive;
	logic enhanced;
	logic [1:0] swap_eff;
	logic [1:0] sel;
	logic [1:0] phys_sel;
	logic [3:0] motor_log;
	logic [3:0] motor_phys;
	logic [3:0] sel_avail;
	logic [1:0] drive_id;
	logic [7:0] mdt_read;
	logic [31:0] nxt_rdata;
	logic sw_reset;

	// One wait cycle on every access keeps read data registered
	assign wr_acc = avs_write_in && ack_ff;
	assign rd_acc = avs_read_in && ack_ff;
	assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_ff;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (avs_read_in || avs_write_in) && !ack_ff;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sense_meta_ff <= 2'h0;
			sense_ff <= 2'h0;
		end else begin
			sense_meta_ff <= {media_sense_high_in, media_sense_low_in};
			sense_ff <= sense_meta_ff;
		end
	end

	assign four_drive = cfg_ff[`FDSM_CFG_FOUR_DRIVE];
	assign enhanced = cfg_ff[`FDSM_CFG_ENHANCED];
	assign sw_reset = !dmo_ff[`FDSM_DMO_RUN];

	// Only hardware reset touches these; software reset leaves them alone
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			dmo_ff <= `FDSM_DMO_RESET;
		end else if (wr_acc && avs_address_in == `FDSM_IDX_DRIVE_MOTOR_OUTPUT && avs_byteenable_in[0]) begin
			dmo_ff <= avs_writedata_in[7:0];
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cfg_ff <= `FDSM_CFG_RESET;
			did_ff <= `FDSM_DID_RESET;
		end else if (wr_acc && avs_byteenable_in[0]) begin
			if (avs_address_in == `FDSM_IDX_CONFIG) begin
				cfg_ff <= avs_writedata_in[7:0];
			end
			if (avs_address_in == `FDSM_IDX_DRIVE_ID) begin
				did_ff <= avs_writedata_in[7:0];
			end
		end
	end

	// Tape/swap bits clear on hardware reset; swap bits only writable when enhanced
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tape_swap_ff <= 4'(`FDSM_MDT_RESET);
		end else if (wr_acc && avs_address_in == `FDSM_IDX_MEDIA_DRIVE_TYPE && avs_byteenable_in[0]) begin
			tape_swap_ff[1:0] <= avs_writedata_in[1:0];
			if (enhanced) begin
				tape_swap_ff[3:2] <= avs_writedata_in[3:2];
			end
		end
	end

	// Stretch soft reset so it lasts at least the minimum low time
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_cnt_ff <= 8'h00;
			run_prev_ff <= 1'b0;
		end else begin
			run_prev_ff <= dmo_ff[`FDSM_DMO_RUN];
			if (sw_reset) begin
				rst_cnt_ff <= 8'(SOFT_RESET_CYC);
			end else if (rst_cnt_ff != 8'h00) begin
				rst_cnt_ff <= rst_cnt_ff - 8'h01;
			end
		end
	end

	assign ctrl_reset_out = sw_reset || (rst_cnt_ff != 8'h00);
	assign soft_reset_pulse_out = run_prev_ff && sw_reset;

	// Logical swap never applies in four-drive mode or legacy register mode
	always_comb begin
		swap_eff = 2'h0;
		if (enhanced && !four_drive && tape_swap_ff[3:2] != 2'h3) begin
			swap_eff = tape_swap_ff[3:2];
		end
	end

	assign sel = dmo_ff[1:0];
	assign motor_log = dmo_ff[7:4];
	assign sel_avail = {four_drive, four_drive || swap_eff == 2'h2, 2'h3};

	// Map logical drive numbers to pins according to the swap
	always_comb begin
		phys_sel = sel;
		motor_phys = motor_log;
		if (swap_eff == 2'h1) begin
			phys_sel = (sel == 2'h0) ? 2'h1 : (sel == 2'h1) ? 2'h0 : sel;
			motor_phys = {motor_log[3:2], motor_log[0], motor_log[1]};
		end else if (swap_eff == 2'h2) begin
			phys_sel = (sel == 2'h0) ? 2'h2 : (sel == 2'h2) ? 2'h0 : sel;
			motor_phys = {motor_log[3], motor_log[0], motor_log[1], motor_log[2]};
		end
	end

	// Registered drive outputs; selects and motors active low, encoded lines active high
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			drive_out <= '{drive_sel_n: 4'hf, motor_n: 4'hf, enc_sel: 2'h0, enc_motor: 1'b0};
		end else begin
			for (int i = 0; i < 4; i++) begin
				drive_out.drive_sel_n[i] <= !(phys_sel == 2'(i) && sel_avail[i]);
				drive_out.motor_n[i] <= !(motor_phys[i] && sel_avail[i]);
			end
			drive_out.enc_sel <= four_drive ? sel : 2'h0;
			drive_out.enc_motor <= four_drive && motor_log[sel];
		end
	end

	// DMA gating: alternative mode keeps lines enabled even during soft reset; hardware reset disables them
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			dma_out <= '{drq_oe_n: 1'b1, irq_oe_n: 1'b1, dack_en: 1'b0, tc_en: 1'b0};
		end else if (cfg_ff[`FDSM_CFG_ALT_MODE]) begin
			dma_out <= '{drq_oe_n: 1'b0, irq_oe_n: 1'b0, dack_en: 1'b1, tc_en: 1'b1};
		end else begin
			dma_out.drq_oe_n <= !dmo_ff[`FDSM_DMO_DMA];
			dma_out.irq_oe_n <= !dmo_ff[`FDSM_DMO_DMA];
			dma_out.dack_en <= dmo_ff[`FDSM_DMO_DMA];
			dma_out.tc_en <= dmo_ff[`FDSM_DMO_DMA];
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tape_drive_out <= 2'h0;
		end else begin
			tape_drive_out <= tape_swap_ff[1:0];
		end
	end

	// Drives 2 and 3 have no ID field; they always read 11, not the 00 reset value
	always_comb begin
		drive_id = 2'h3;
		if (sel == 2'h0) begin
			drive_id = did_ff[1:0];
		end else if (sel == 2'h1) begin
			drive_id = did_ff[3:2];
		end
	end

	// Undriven bits have no bus equivalent, so they read as zero
	assign mdt_read = enhanced ? {sense_ff, drive_id, tape_swap_ff} : {6'h00, tape_swap_ff[1:0]};

	always_comb begin
		nxt_rdata = 32'h0;
		unique case (avs_address_in)
			`FDSM_IDX_CONFIG: nxt_rdata = {24'h0, cfg_ff};
			`FDSM_IDX_DRIVE_ID: nxt_rdata = {24'h0, did_ff};
			`FDSM_IDX_DRIVE_MOTOR_OUTPUT: nxt_rdata = {24'h0, dmo_ff};
			`FDSM_IDX_MEDIA_DRIVE_TYPE: nxt_rdata = {24'h0, mdt_read};
			`FDSM_IDX_STATUS: nxt_rdata = {30'h0, sense_ff[0], ctrl_reset_out};
			default: nxt_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_ff <= 32'h0;
		end else if (avs_read_in && !ack_ff) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign avs_readdata_out = rdata_ff;
endmodule

// ==== bench/fdsm_chk.sv ====
// Checker for the drive/motor register block, bound onto fdsm_top.
// Assumes only its ports are seen; stored bytes are rebuilt from taken writes.
`timescale 1ns/100ps
module fdsm_chk (
	// Clock, reset, bus
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [3:0] avs_address_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic avs_waitrequest_out,
	// Watched outputs
	input wire fdsm_pkg::fdsm_drive_s drive_out,
	input wire logic [1:0] tape_drive_out,
	input wire logic ctrl_reset_out,
	input wire logic soft_reset_pulse_out,
	input wire fdsm_pkg::fdsm_dma_s dma_out
);
	import fdsm_pkg::*;
	logic [7:0] cfg_ff, dmo_ff;
	logic [3:0] mdt_ff;
	// Pins lag a stored byte by one cycle, so that cycle is skipped
	logic busy_ff;
	logic wt;
	logic [7:0] wd;
	assign wt = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
	assign wd = avs_writedata_in[7:0];
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cfg_ff <= 8'h00;
			dmo_ff <= 8'h00;
			mdt_ff <= 4'h0;
			busy_ff <= 1'b1;
		end else begin
			busy_ff <= wt;
			if (wt && avs_address_in == 4'h0) cfg_ff <= wd;
			if (wt && avs_address_in == 4'h2) dmo_ff <= wd;
			if (wt && avs_address_in == 4'h3) mdt_ff <= {cfg_ff[6] ? wd[3:2] : mdt_ff[3:2], wd[1:0]};
		end
	end
	default clocking dc @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	a_reset_hold: assert property (!dmo_ff[2] |-> ctrl_reset_out) else $error("left reset early");
	a_pulse_fall: assert property (wt && avs_address_in == 4'h2 && dmo_ff[2] && !wd[2] |-> ##[1:2] soft_reset_pulse_out)
		else $error("no reset pulse");
	a_pulse_once: assert property (soft_reset_pulse_out |=> !soft_reset_pulse_out) else $error("long pulse");
	a_dma_gate: assert property (!busy_ff && !cfg_ff[0] |-> dma_out == (dmo_ff[3] ? 4'h3 : 4'hc))
		else $error("dma gate wrong");
	a_dma_alt: assert property (!busy_ff && cfg_ff[0] |-> dma_out == 4'h3) else $error("dma not on");
	a_motor_pair: assert property (!busy_ff && !cfg_ff[7] && mdt_ff[3:2] == 2'h0 |-> drive_out.motor_n[1:0] == ~dmo_ff[5:4])
		else $error("motor 0/1 wrong");
	a_sel_onehot: assert property (!busy_ff && !cfg_ff[7] && mdt_ff[3:2] == 2'h0 && !dmo_ff[1] |->
		drive_out.drive_sel_n == ~(4'h1 << dmo_ff[0])) else $error("select wrong");
	a_upper_off: assert property (!busy_ff && !cfg_ff[7] && mdt_ff[3:2] != 2'h2 |->
		drive_out.drive_sel_n[3:2] == 2'h3 && drive_out.motor_n[3:2] == 2'h3) else $error("drive 2/3 on");
	a_enc_lines: assert property (!busy_ff && cfg_ff[7] |-> drive_out.enc_sel == dmo_ff[1:0] &&
		drive_out.enc_motor == dmo_ff[4 + dmo_ff[1:0]]) else $error("encoded lines wrong");
	a_tape_copy: assert property (!busy_ff |-> tape_drive_out == mdt_ff[1:0]) else $error("tape wrong");
endmodule
bind fdsm_top fdsm_chk fdsm_chk_i (.*);

// ==== bench/fdsm_drive_model.sv ====
// Floppy drives on the far side: the selected drive reports its media type.
// Assumes active-low selects; idle sense pins sit high on their pull-ups.
`timescale 1ns/100ps
module fdsm_drive_model (
	// From the block
	input wire fdsm_pkg::fdsm_drive_s drive_in,
	input wire logic [7:0] media_in,
	// Media sense pins
	output logic media_sense_low_out,
	output logic media_sense_high_out
);
	import fdsm_pkg::*;
	always_comb begin
		{media_sense_high_out, media_sense_low_out} = 2'h3;
		for (int i = 0; i < 4; i++) begin
			if (!drive_in.drive_sel_n[i]) begin
				{media_sense_high_out, media_sense_low_out} = media_in[2*i +: 2];
			end
		end
	end
endmodule

// ==== bench/fdsm_top_tb.sv ====
// Bench for the drive/motor register block: Avalon master tasks and scenarios.
// Assumes the checker binds itself and the drive model feeds the sense pins.
`timescale 1ns/100ps
module fdsm_top_tb;
	import fdsm_pkg::*;
	logic clk_in, rstn_in, avs_read_in, avs_write_in, avs_waitrequest_out, ws, cr;
	logic [3:0] avs_address_in, avs_byteenable_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, rs;
	logic media_sense_low_in, media_sense_high_in, ctrl_reset_out, soft_reset_pulse_out;
	logic [1:0] tape_drive_out, tp;
	fdsm_drive_s drive_out, dv;
	fdsm_dma_s dma_out, dm;
	int n_errors, tests_run;
	fdsm_top fdsm_top_i (.*);
	fdsm_drive_model fdsm_drive_model_i (.drive_in(drive_out), .media_in(8'h1b),
		.media_sense_low_out(media_sense_low_in), .media_sense_high_out(media_sense_high_in));
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	// Outputs are sampled mid-cycle so no edge race decides a compare
	always @(negedge clk_in) begin
		{ws, rs, cr, tp, dv, dm} <= {avs_waitrequest_out, avs_readdata_out, ctrl_reset_out, tape_drive_out, drive_out, dma_out};
	end
	task automatic end_of_test;
		$display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
		int i;
		avs_address_in <= a;
		avs_writedata_in <= {24'h0, d};
		avs_byteenable_in <= be;
		avs_write_in <= w;
		avs_read_in <= !w;
		i = 0;
		do begin
			@(posedge clk_in);
			i++;
		end while (ws !== 1'b0 && i < 16);
		if (ws !== 1'b0) begin
			n_errors++;
			end_of_test();
		end
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		repeat (2) @(posedge clk_in);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00, 4'h1);
		chk(rs, e);
	endtask
	task automatic t_reset;
		chk(cr, 1'b1);
		rd(4'h2, 32'h0);
		rd(4'h3, 32'h0);
		bus(1'b1, 4'h2, 8'hff, 4'h0);
		rd(4'h2, 32'h0);
		wr(4'h9, 8'h5a);
		rd(4'h9, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_dor;
		wr(4'h2, 8'h1c);
		rd(4'h2, 32'h1c);
		chk({dv.drive_sel_n, dv.motor_n}, 8'hee);
		wr(4'h2, 8'h2d);
		chk({dv.drive_sel_n, dv.motor_n}, 8'hdd);
		wr(4'h2, 8'h4e);
		chk({dv.drive_sel_n, dv.motor_n}, 8'hff);
		wr(4'h0, 8'h80);
		wr(4'h2, 8'h8f);
		chk({dv.enc_sel, dv.enc_motor}, 3'h7);
		wr(4'h2, 8'h0f);
		chk({dv.enc_sel, dv.enc_motor}, 3'h6);
		wr(4'h2, 8'h4e);
		chk({dv.enc_sel, dv.enc_motor}, 3'h5);
		wr(4'h0, 8'h00);
		$display("test drive select done");
	endtask
	task automatic t_soft;
		wr(4'h2, 8'h18);
		chk(cr, 1'b1);
		chk(dm, 4'h3);
		wr(4'h2, 8'h1c);
		rd(4'h2, 32'h1c);
		wr(4'h2, 8'h14);
		chk(dm, 4'hc);
		wr(4'h0, 8'h01);
		wr(4'h2, 8'h10);
		chk(dm, 4'h3);
		wr(4'h0, 8'h00);
		$display("test soft reset done");
	endtask
	task automatic t_type;
		wr(4'h3, 8'hff);
		rd(4'h3, 32'h3);
		for (int t = 0; t < 4; t++) begin
			wr(4'h3, t[7:0]);
			chk(tp, t[1:0]);
		end
		wr(4'h1, 8'h0e);
		wr(4'h0, 8'h40);
		wr(4'h2, 8'h1c);
		wr(4'h3, 8'h01);
		rd(4'h3, 32'he1);
		wr(4'h2, 8'h2d);
		// Sense pins pass the pin register and two sync stages before a read sees them
		repeat (4) @(posedge clk_in);
		rd(4'h3, 32'hb1);
		wr(4'h3, 8'h05);
		wr(4'h2, 8'h1c);
		chk({dv.drive_sel_n, dv.motor_n}, 8'hdd);
		wr(4'h3, 8'h09);
		chk({dv.drive_sel_n, dv.motor_n}, 8'hbb);
		wr(4'h0, 8'hc0);
		wr(4'h2, 8'h4e);
		chk({dv.enc_sel, dv.enc_motor}, 3'h5);
		$display("test media type done");
	endtask
	initial begin
		n_errors = 0;
		tests_run = 0;
		rstn_in = 1'b0;
		{avs_read_in, avs_write_in, avs_address_in, avs_byteenable_in, avs_writedata_in} = '0;
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		t_reset();
		t_dor();
		t_soft();
		t_type();
		end_of_test();
	end
endmodule
